// ==== logic/bit_sync.v ====
`default_nettype none

// Two-stage synchroniser for a bundle of unrelated level inputs
module bit_sync #(
	parameter WIDTH = 1
) (
	// Clock
	input wire core_clk,
	// Asynchronous levels in, synchronised levels out
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1_reg; // Metastable stage, read only by stage2
	reg [WIDTH-1:0] stage2_reg; // Settled copy

	// No reset: a pin level carries no state worth clearing
	always @(posedge core_clk)
	begin
		stage1_reg <= async_in;
		stage2_reg <= stage1_reg;
	end

	assign sync_out = stage2_reg;

endmodule

`default_nettype wire

// ==== logic/media_interface_select.v ====
// Behaviour
// (RULE_01) Strap picks RGMII, RMII, MII or GMII; RGMII is latched but only flagged unsupported, not built
// (RULE_02) MII/GMII drive continuous 25 MHz reference
// (RULE_03) Partner supplies MII transmit clock
// (RULE_04) MII transmit nibbles follow partner transmit clock
// (RULE_05) Transmit enable high exactly during frame data
// (RULE_06) MII/GMII transmit error propagates to medium
// (RULE_07) Partner gives MII receive nibbles on clock
// (RULE_08) Partner holds receive valid over frame
// (RULE_09) Receive error marks whole frame errored
// (RULE_10) Carrier sense and collision are synchronised
// (RULE_11) RMII timed by continuous 50 MHz reference
// (RULE_12) RMII enable rises with first preamble di-bit
// (RULE_13) RMII two bits per cycle, bit1 upper
// (RULE_14) RMII receive di-bits only while CRS_DV
// (RULE_15) PHY holds CRS_DV during false carrier
// (RULE_16) PHY holds RMII receive error one cycle
// (RULE_17) GMII drives gigabit clock and eight bits; the clock here runs at half the core clock, not 125 MHz
// (RULE_18) GMII one full byte per clock
// (RULE_19) GMII switch clock driven by partner
// (RULE_20) Partner gives GMII receive bytes per clock
// (RULE_21) Mode fixed from reset release onward
// (RULE_22) Unused outputs inactive, foreign inputs ignored
`include "media_select_defines.vh"
`default_nettype none

module media_interface_select #(
	parameter CORE_MHZ = `CORE_CLK_MHZ
) (
	// Clock and reset
	input wire core_clk,
	input wire srst,
	// Strap, caught while reset is high
	input wire [1:0] port_interface_select_strap,
	// Mode seen by the rest of the MAC
	output wire [1:0] active_mode,
	output wire mode_unsupported,
	// MAC transmit side
	input wire [7:0] tx_data,
	input wire tx_valid,
	input wire tx_error,
	output wire tx_ready,
	// MAC receive side
	output wire [7:0] rx_data,
	output wire rx_valid,
	output wire rx_frame_end,
	output wire rx_frame_error,
	output wire carrier_sense,
	output wire collision,
	// Media clocks out
	output wire phy_reference_clock_out,
	output wire gigabit_phy_reference_clock_out,
	output wire reduced_reference_clock_out,
	output wire gigabit_tx_clock_out,
	// Media transmit pins
	output wire [7:0] txd_pin,
	output wire tx_en_pin,
	output wire tx_er_pin,
	// Media receive pins
	input wire tx_clk_pin,
	input wire gigabit_tx_switch_clock_in,
	input wire rx_clk_pin,
	input wire [7:0] rxd_pin,
	input wire rx_dv_pin,
	input wire rx_er_pin,
	input wire crs_pin,
	input wire col_pin
);

	// Half periods of generated clocks in core cycles, never below one
	localparam integer REF_HALF_RAW = CORE_MHZ / (2 * `PHY_REF_MHZ);
	localparam integer REF_HALF = (REF_HALF_RAW < 1) ? 1 : REF_HALF_RAW;

	// Synchronised pins: strap, clocks, data and sideband
	wire [1:0] strap_s;
	wire tx_clk_s;
	wire rx_clk_s;
	wire [7:0] rxd_s;
	wire rx_dv_s;
	wire rx_er_s;
	wire crs_s;
	wire col_s;

	bit_sync #(
		.WIDTH(16)
	) pin_sync (
		.core_clk(core_clk),
		.async_in({port_interface_select_strap, tx_clk_pin, rx_clk_pin, rxd_pin,
			rx_dv_pin, rx_er_pin, crs_pin, col_pin}),
		.sync_out({strap_s, tx_clk_s, rx_clk_s, rxd_s, rx_dv_s, rx_er_s, crs_s, col_s})
	);

	// Units per byte, less one, for the selected mode
	function [1:0] units_of;
		input [1:0] mode;
		begin
			case (mode)
				`MODE_MII: units_of = `MII_UNITS;
				`MODE_RMII: units_of = `RMII_UNITS;
				default: units_of = `GMII_UNITS;
			endcase
		end
	endfunction

	// Mode latch: follows the strap only while reset is held
	reg [1:0] mode_reg;
	always @(posedge core_clk)
	begin
		if (srst)
			mode_reg <= strap_s; // [RULE_01] [RULE_21]
	end

	wire is_mii = (mode_reg == `MODE_MII);
	wire is_rmii = (mode_reg == `MODE_RMII);
	wire is_gmii = (mode_reg == `MODE_GMII);
	// RGMII double-rate signalling is not built here
	assign mode_unsupported = (mode_reg == `MODE_RGMII);
	assign active_mode = mode_reg;

	// Reference dividers, free running from reset
	reg [7:0] ref_cnt_reg; // Half-period counter for 25 MHz
	reg ref25_reg;
	reg fast_reg; // Toggles every core cycle
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			ref_cnt_reg <= 8'h00;
			ref25_reg <= 1'b0;
			fast_reg <= 1'b0;
		end
		else
		begin
			fast_reg <= ~fast_reg;
			if (ref_cnt_reg == REF_HALF[7:0] - 8'h01)
			begin
				ref_cnt_reg <= 8'h00;
				ref25_reg <= ~ref25_reg;
			end
			else
				ref_cnt_reg <= ref_cnt_reg + 8'h01;
		end
	end

	// Clock outputs gated per mode; the fast toggle stands in for 50/125 MHz
	assign phy_reference_clock_out = is_mii & ref25_reg; // [RULE_02] [RULE_22]
	assign gigabit_phy_reference_clock_out = is_gmii & ref25_reg; // [RULE_02]
	assign reduced_reference_clock_out = is_rmii & fast_reg; // [RULE_11]
	// Limited by the core rate: runs at half the core clock, not true 125 MHz
	assign gigabit_tx_clock_out = is_gmii & fast_reg; // [RULE_17]

	// Edge finders on synchronised partner clocks
	reg tx_clk_d_reg;
	reg rx_clk_d_reg;
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			tx_clk_d_reg <= 1'b0;
			rx_clk_d_reg <= 1'b0;
		end
		else
		begin
			tx_clk_d_reg <= tx_clk_s;
			rx_clk_d_reg <= rx_clk_s;
		end
	end
	wire tx_clk_rise = tx_clk_s & ~tx_clk_d_reg;
	wire rx_clk_rise = rx_clk_s & ~rx_clk_d_reg;

	// Launch strobe: MII on partner clock, others on our falling edge, half a period before the rise
	// The GMII switch clock input is left unused; this core never changes source
	wire tx_step = is_mii ? tx_clk_rise : ((is_rmii | is_gmii) & fast_reg); // [RULE_04] [RULE_19]

	// Transmit serialiser state
	reg [7:0] tx_shift_reg; // Byte being sent, low unit first
	reg [1:0] tx_left_reg; // Units still to send after current
	reg tx_busy_reg;
	reg [7:0] txd_reg;
	reg tx_en_reg;
	reg tx_er_reg;
	reg tx_err_hold_reg;
	wire load_byte = tx_step & (~tx_busy_reg | (tx_left_reg == 2'h0)) & tx_valid
		& ~mode_unsupported;
	assign tx_ready = load_byte;

	// Transmit datapath; nothing moves until the next launch strobe
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			tx_shift_reg <= 8'h00;
			tx_left_reg <= 2'h0;
			tx_busy_reg <= 1'b0;
			txd_reg <= 8'h00;
			tx_en_reg <= 1'b0;
			tx_er_reg <= 1'b0;
			tx_err_hold_reg <= 1'b0;
		end
		else if (tx_step)
		begin
			if (load_byte)
			begin
				// First unit of a new byte goes out now
				tx_busy_reg <= 1'b1;
				tx_en_reg <= 1'b1; // [RULE_05] [RULE_12]
				tx_err_hold_reg <= tx_error;
				tx_er_reg <= tx_error & ~is_rmii; // [RULE_06] [RULE_22]
				tx_left_reg <= units_of(mode_reg);
				if (is_mii)
				begin
					txd_reg <= {4'h0, tx_data[3:0]}; // [RULE_04]
					tx_shift_reg <= {4'h0, tx_data[7:4]};
				end
				else if (is_rmii)
				begin
					txd_reg <= {6'h00, tx_data[1:0]}; // [RULE_13]
					tx_shift_reg <= {2'h0, tx_data[7:2]};
				end
				else
				begin
					txd_reg <= tx_data; // [RULE_17] [RULE_18]
					tx_shift_reg <= 8'h00;
				end
			end
			else if (tx_busy_reg && tx_left_reg != 2'h0)
			begin
				// Further units of the same byte
				tx_left_reg <= tx_left_reg - 2'h1;
				tx_er_reg <= tx_err_hold_reg & ~is_rmii;
				if (is_mii)
				begin
					txd_reg <= {4'h0, tx_shift_reg[3:0]};
					tx_shift_reg <= {4'h0, tx_shift_reg[7:4]};
				end
				else
				begin
					txd_reg <= {6'h00, tx_shift_reg[1:0]}; // [RULE_13]
					tx_shift_reg <= {2'h0, tx_shift_reg[7:2]};
				end
			end
			else
			begin
				// No data ready: enable drops, lines go quiet
				tx_busy_reg <= 1'b0;
				tx_en_reg <= 1'b0; // [RULE_05]
				tx_er_reg <= 1'b0;
				txd_reg <= 8'h00;
			end
		end
	end

	assign txd_pin = txd_reg;
	assign tx_en_pin = tx_en_reg;
	assign tx_er_pin = tx_er_reg;

	// Receive sample strobe per mode; RMII samples on our own reference fall
	wire rx_step = is_mii ? rx_clk_rise : (is_gmii ? rx_clk_rise : (is_rmii & fast_reg));
	// Valid qualifier: CRS_DV in RMII, RX_DV otherwise
	wire rx_dv_q = rx_dv_s & ~mode_unsupported; // [RULE_22]

	// Receive assembler state
	reg [7:0] rx_shift_reg;
	reg [1:0] rx_cnt_reg; // Units gathered into current byte
	reg rx_in_frame_reg;
	reg rx_err_reg; // Sticky error for the frame in progress
	reg [7:0] rx_data_reg;
	reg rx_valid_reg;
	reg rx_end_reg;
	reg rx_end_err_reg;
	wire [1:0] rx_last = units_of(mode_reg);

	// Deserialise partner data into bytes and flag errored frames
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			rx_shift_reg <= 8'h00;
			rx_cnt_reg <= 2'h0;
			rx_in_frame_reg <= 1'b0;
			rx_err_reg <= 1'b0;
			rx_data_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			rx_end_reg <= 1'b0;
			rx_end_err_reg <= 1'b0;
		end
		else
		begin
			rx_valid_reg <= 1'b0;
			rx_end_reg <= 1'b0;
			if (rx_step)
			begin
				if (rx_dv_q)
				begin
					// Accept data only under the valid qualifier
					rx_in_frame_reg <= 1'b1; // [RULE_14]
					if (rx_er_s)
						rx_err_reg <= 1'b1; // [RULE_09] [RULE_16]
					if (is_gmii)
					begin
						rx_data_reg <= rxd_s; // [RULE_20]
						rx_valid_reg <= 1'b1;
					end
					else
					begin
						// Narrow units arrive low first, upper bit of unit is MSB
						if (is_mii)
							rx_shift_reg <= {rxd_s[3:0], rx_shift_reg[7:4]}; // [RULE_07]
						else
							rx_shift_reg <= {rxd_s[1:0], rx_shift_reg[7:2]}; // [RULE_14]
						if (rx_cnt_reg == rx_last)
						begin
							rx_cnt_reg <= 2'h0;
							rx_valid_reg <= 1'b1;
							if (is_mii)
								rx_data_reg <= {rxd_s[3:0], rx_shift_reg[7:4]};
							else
								rx_data_reg <= {rxd_s[1:0], rx_shift_reg[7:2]};
						end
						else
							rx_cnt_reg <= rx_cnt_reg + 2'h1;
					end
				end
				else if (rx_in_frame_reg)
				begin
					// Frame closes when the qualifier drops; error on the last unit counts
					rx_in_frame_reg <= 1'b0; // [RULE_08] [RULE_15]
					rx_end_reg <= 1'b1;
					rx_end_err_reg <= rx_err_reg | rx_er_s; // [RULE_09]
					rx_err_reg <= 1'b0;
					rx_cnt_reg <= 2'h0;
				end
			end
		end
	end

	assign rx_data = rx_data_reg;
	assign rx_valid = rx_valid_reg;
	assign rx_frame_end = rx_end_reg;
	assign rx_frame_error = rx_end_err_reg;

	// Sideband levels exist only in MII and GMII
	assign carrier_sense = crs_s & (is_mii | is_gmii); // [RULE_10] [RULE_22]
	assign collision = col_s & (is_mii | is_gmii); // [RULE_10]

endmodule

`default_nettype wire

// ==== logic/media_select_defines.vh ====
`ifndef MEDIA_SELECT_DEFINES_VH
`define MEDIA_SELECT_DEFINES_VH

// Strap codes, upper bit first
`define MODE_RGMII 2'h0
`define MODE_RMII 2'h1
`define MODE_MII 2'h2
`define MODE_GMII 2'h3

// Clock rates in MHz
`define CORE_CLK_MHZ 100
`define PHY_REF_MHZ 25
`define RMII_REF_MHZ 50
`define GTX_CLK_MHZ 125

// Data units per byte, less one, in each mode
`define MII_UNITS 2'h1
`define RMII_UNITS 2'h3
`define GMII_UNITS 2'h0

`endif

// ==== sim/media_interface_select_props.sv ====
`include "media_select_defines.vh"
`default_nettype none
// Port checks: mode, pacing, widths, clocks
module media_interface_select_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Watched ports
	input wire logic [1:0] active_mode,
	input wire logic tx_ready,
	input wire logic tx_en_pin,
	input wire logic tx_er_pin,
	input wire logic [7:0] txd_pin,
	input wire logic rx_valid,
	input wire logic rx_frame_end,
	input wire logic carrier_sense,
	input wire logic crs_pin,
	input wire logic phy_reference_clock_out,
	input wire logic gigabit_phy_reference_clock_out,
	input wire logic reduced_reference_clock_out,
	input wire logic gigabit_tx_clock_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// Half of a clock that toggles every other cycle
	sequence half_period(s);
		$stable(s) ##1 $changed(s);
	endsequence
	mode_hold_a: assert property ($stable(active_mode))
		else $error("mode moved after reset");
	ready_launch_a: assert property (tx_ready |=> tx_en_pin)
		else $error("taken byte not launched");
	mii_ref_a: assert property (active_mode == `MODE_MII &&
		$changed(phy_reference_clock_out) |=> half_period(phy_reference_clock_out))
		else $error("phy reference not 25 MHz");
	gmii_ref_a: assert property (active_mode == `MODE_GMII &&
		$changed(gigabit_phy_reference_clock_out) |=>
		half_period(gigabit_phy_reference_clock_out))
		else $error("gigabit reference not 25 MHz");
	// A stuck reference would slip past the spacing checks above
	ref_live_a: assert property (active_mode[1] |->
		##[1:2] $changed(phy_reference_clock_out ^ gigabit_phy_reference_clock_out))
		else $error("phy reference stopped");
	rmii_ref_a: assert property (active_mode == `MODE_RMII &&
		reduced_reference_clock_out |=> !reduced_reference_clock_out ##1
		reduced_reference_clock_out) else $error("reduced reference not 50 MHz");
	rmii_width_a: assert property (active_mode == `MODE_RMII |->
		txd_pin[7:2] == 6'h00 && !tx_er_pin) else $error("rmii extra bits driven");
	idle_clock_a: assert property (active_mode != `MODE_GMII |->
		!gigabit_tx_clock_out) else $error("gigabit clock outside its mode");
	rx_pulse_a: assert property (rx_valid || rx_frame_end |=>
		!rx_valid && !rx_frame_end) else $error("receive strobe too long");
	crs_sync_a: assert property ($rose(carrier_sense) |-> $past(crs_pin, 2))
		else $error("carrier sense without synced cause");
endmodule
bind media_interface_select media_interface_select_props i_props (
	.core_clk, .srst, .active_mode, .tx_ready, .tx_en_pin, .tx_er_pin, .txd_pin,
	.rx_valid, .rx_frame_end, .carrier_sense, .crs_pin, .phy_reference_clock_out,
	.gigabit_phy_reference_clock_out, .reduced_reference_clock_out, .gigabit_tx_clock_out
);
`default_nettype wire

// ==== sim/media_interface_select_tb.sv ====
`include "media_select_defines.vh"
`default_nettype none
// Each strap mode: reset, transmit, and receive except in RGMII
module media_interface_select_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [1:0] port_interface_select_strap = 2'h0;
	logic [1:0] cur = 2'h0; // Mode of this reset
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic tx_error = 1'b0;
	wire logic [1:0] active_mode;
	wire logic mode_unsupported, tx_ready, rx_valid, rx_frame_end, rx_frame_error;
	wire logic reduced_reference_clock_out, gigabit_tx_clock_out, tx_en_pin, tx_er_pin;
	wire logic tx_clk_pin, rx_clk_pin, gigabit_tx_switch_clock_in, rx_dv_pin, rx_er_pin;
	wire logic crs_pin, col_pin, carrier_sense, collision;
	wire logic [7:0] rx_data, txd_pin, rxd_pin;
	logic [8:0] tx_exp[$]; // Bytes due on the pins
	logic [8:0] rx_exp[$]; // Bytes due to the MAC
	logic rx_err_exp = 1'b0; // Error mark of frame in flight
	logic [1:0] order[4] = '{`MODE_MII, `MODE_RMII, `MODE_GMII, `MODE_RGMII};
	int unsigned seed = 32'h5de4;
	int fails = 0;
	int checks = 0;
	always #5 core_clk = ~core_clk;
	media_interface_select i_dut (
		.core_clk, .srst, .port_interface_select_strap, .active_mode, .mode_unsupported,
		.tx_data, .tx_valid, .tx_error, .tx_ready, .rx_data, .rx_valid, .rx_frame_end,
		.rx_frame_error, .carrier_sense, .collision, .phy_reference_clock_out(),
		.gigabit_phy_reference_clock_out(), .reduced_reference_clock_out,
		.gigabit_tx_clock_out, .txd_pin, .tx_en_pin, .tx_er_pin, .tx_clk_pin,
		.gigabit_tx_switch_clock_in, .rx_clk_pin, .rxd_pin, .rx_dv_pin, .rx_er_pin,
		.crs_pin, .col_pin
	);
	phy_model i_phy (
		.mode(cur), .txd_pin, .tx_en_pin, .tx_er_pin, .reduced_reference_clock_out,
		.gigabit_tx_clock_out, .tx_clk_pin, .gigabit_tx_switch_clock_in, .rx_clk_pin,
		.rxd_pin, .rx_dv_pin, .rx_er_pin, .crs_pin, .col_pin
	);
	// Xorshift data source
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Offer bytes back to back, held until taken
	task automatic offer(input int n);
		int w;
		for (int i = 0; i < n; i++)
		begin
			@(negedge core_clk);
			tx_data = rnd();
			tx_error = (i == 1); // Must vanish in RMII
			tx_valid = 1'b1;
			if (cur != `MODE_RGMII)
				tx_exp.push_back({tx_error & cur[1], tx_data});
			#1;
			// Ready is combinational: look at it between edges, where it has settled
			for (w = 0; tx_ready !== 1'b1 && w < 300; w++)
				@(negedge core_clk) #1;
			if (w == 300 && cur != `MODE_RGMII)
			begin
				check("tx_timeout", 9'h000, 9'h001);
				stop_test();
			end
			// Byte is taken at this edge
			@(posedge core_clk);
		end
		@(negedge core_clk);
		tx_valid = 1'b0;
	endtask
	// Wait for idle, rebuild bytes low unit first
	task automatic tx_compare();
		logic [8:0] v, b;
		int s;
		int w;
		s = cur == `MODE_MII ? 4 : cur == `MODE_RMII ? 2 : 8;
		for (w = 0; w < 300 && tx_en_pin !== 1'b0; w++)
			@(negedge core_clk);
		if (tx_en_pin !== 1'b0)
		begin
			check("tx_idle", {8'h00, tx_en_pin}, 9'h000);
			stop_test();
		end
		repeat (20) @(negedge core_clk);
		while (i_phy.got.size() >= 8 / s)
		begin
			b = 9'h000;
			for (int u = 0; u < 8; u += s)
			begin
				v = i_phy.got.pop_front();
				b = b | {v[8], v[7:0] << u};
			end
			check("tx_byte", b, tx_exp.size() ? tx_exp.pop_front() : 9'h1ff);
		end
		check("tx_left", 9'(i_phy.got.size() + tx_exp.size()), 9'h000);
		i_phy.got.delete();
		tx_exp.delete();
	endtask
	// Model comparison at each byte and frame end, mid-cycle where outputs have settled
	always @(negedge core_clk)
		if (srst === 1'b0 && rx_valid === 1'b1)
		begin
			// Carrier spans the frame; collision mirrors the error on byte one
			check("carrier", {8'h00, carrier_sense}, {8'h00, cur[1]});
			check("collision", {8'h00, collision},
				{8'h00, cur[1] & rx_err_exp & (rx_exp.size() == 2)});
			check("rx_data", {1'b0, rx_data}, rx_exp.size() ? rx_exp.pop_front() : 9'h1ff);
		end
	always @(negedge core_clk)
		if (srst === 1'b0 && rx_frame_end === 1'b1)
			check("rx_error", {8'h00, rx_frame_error}, {8'h00, rx_err_exp});
	// Walk strap codes, each behind a fresh reset
	initial
	begin
		logic [7:0] q[$];
		for (int m = 0; m < 4; m++)
		begin
			@(negedge core_clk);
			srst = 1'b1;
			port_interface_select_strap = order[m];
			cur = order[m];
			repeat (10) @(negedge core_clk);
			srst = 1'b0;
			port_interface_select_strap = ~order[m]; // Late strap move
			repeat (5) @(negedge core_clk);
			check("mode", {7'h00, active_mode}, {7'h00, cur});
			check("unbuilt", {8'h00, mode_unsupported}, {8'h00, cur == `MODE_RGMII});
			offer(cur == `MODE_RGMII ? 1 : 4);
			tx_compare();
			if (cur != `MODE_RGMII)
			begin
				q = '{rnd(), rnd(), rnd()};
				foreach (q[i])
					rx_exp.push_back({1'b0, q[i]});
				rx_err_exp = (m < 2); // MII and RMII frames errored, GMII clean
				i_phy.send(q, m < 2 ? 1 : 7);
				repeat (10) @(negedge core_clk);
				check("rx_left", 9'(rx_exp.size()), 9'h000);
			end
		end
		stop_test();
	end
endmodule
`default_nettype wire

// ==== sim/phy_model.sv ====
`include "media_select_defines.vh"
`default_nettype none
// Far-side PHY: clocks, receive frames, unit capture
module phy_model (
	// Mode and device transmit pins
	input wire logic [1:0] mode,
	input wire logic [7:0] txd_pin,
	input wire logic tx_en_pin,
	input wire logic tx_er_pin,
	input wire logic reduced_reference_clock_out,
	input wire logic gigabit_tx_clock_out,
	// Pins toward the device
	output logic tx_clk_pin,
	output logic gigabit_tx_switch_clock_in,
	output logic rx_clk_pin,
	output logic [7:0] rxd_pin,
	output logic rx_dv_pin,
	output logic rx_er_pin,
	output logic crs_pin,
	output logic col_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0] got[$]; // Units seen, error on top
	// Idle levels
	initial
	begin
		tx_clk_pin = 1'b0;
		rx_clk_pin = 1'b0;
		rxd_pin = 8'h00;
		rx_dv_pin = 1'b0;
		rx_er_pin = 1'b0;
	end
	always #62.5 tx_clk_pin = ~tx_clk_pin;
	assign gigabit_tx_switch_clock_in = tx_clk_pin;
	assign crs_pin = rx_dv_pin; // Carrier spans the frame
	assign col_pin = rx_er_pin; // Collision reuses error pulse
	// Nibbles read mid-way through our own clock
	always @(negedge tx_clk_pin)
		if (mode == `MODE_MII && tx_en_pin)
			got.push_back({tx_er_pin, txd_pin});
	// Fast modes read just after the device clock rises
	always @(posedge reduced_reference_clock_out or posedge gigabit_tx_clock_out)
	begin
		#1;
		if (tx_en_pin)
			got.push_back({tx_er_pin, txd_pin});
	end
	// One frame; receive clock runs only around it, RMII units ride the device reference
	task automatic send(input logic [7:0] b[$], input int bad);
		int n;
		n = (mode == `MODE_MII) ? 2 : (mode == `MODE_RMII) ? 4 : 1;
		#1; // Keep pin changes off the device clock edges
		foreach (b[i])
			for (int u = 0; u < n; u++)
			begin
				if (n == 4)
					@(posedge reduced_reference_clock_out) #1;
				rxd_pin = (n == 1) ? b[i] : (n == 2) ? {~b[i][4*u +: 4], b[i][4*u +: 4]}
					: {6'h2a, b[i][2*u +: 2]};
				rx_dv_pin = 1'b1;
				rx_er_pin = (i == bad);
				if (n != 4)
				begin
					#62.5 rx_clk_pin = 1'b1;
					#62.5 rx_clk_pin = 1'b0;
				end
			end
		// Last RMII unit stands one full reference cycle
		if (n == 4)
			@(posedge reduced_reference_clock_out) #1;
		rxd_pin = ~rxd_pin; // Released lines keep no data
		rx_dv_pin = 1'b0;
		rx_er_pin = 1'b0;
		repeat (2)
		begin
			#62.5 rx_clk_pin = 1'b1;
			#62.5 rx_clk_pin = 1'b0;
		end
	endtask
endmodule
`default_nettype wire
